// File: common/ccdrs_pkg.sv
// constants for the ccd readout sequencing controller
package ccdrs_pkg;

  // counter width for rows and columns
  localparam int CNT_W = 11;

  // vertical frame makeup
  localparam logic [10:0] ROWS_LEAD_DARK  = 11'h002;
  localparam logic [10:0] ROWS_PHOTO      = 11'h4B8;  // 1208
  localparam logic [10:0] ROWS_TRAIL_DARK = 11'h004;
  localparam logic [10:0] ROWS_BUFFER     = 11'h004;
  localparam logic [10:0] ROWS_IMAGE      = 11'h4B0;  // 1200
  localparam logic [10:0] ROWS_TOTAL      =
    ROWS_LEAD_DARK + ROWS_PHOTO + ROWS_TRAIL_DARK;
  localparam logic [10:0] ROW_IMG_FIRST   = ROWS_LEAD_DARK + ROWS_BUFFER;
  localparam logic [10:0] ROW_IMG_LAST    = ROW_IMG_FIRST + ROWS_IMAGE
                                            - 11'h001;

  // horizontal line makeup
  localparam logic [10:0] COLS_EMPTY      = 11'h004;
  localparam logic [10:0] COLS_DARK       = 11'h010;  // 16
  localparam logic [10:0] COLS_PHOTO_SGL  = 11'h648;  // 1608
  localparam logic [10:0] COLS_BUFFER     = 11'h004;
  localparam logic [10:0] COLS_IMAGE_SGL  = 11'h640;  // 1600
  localparam logic [10:0] COLS_IMAGE_DUAL = 11'h320;  // 800 per half
  localparam logic [10:0] LINE_LEN_SGL    = 11'h66C;  // 1644
  localparam logic [10:0] LINE_LEN_DUAL   = 11'h338;  // 824
  localparam logic [10:0] COL_IMG_FIRST   =
    COLS_EMPTY + COLS_DARK + COLS_BUFFER;

  // timing
  localparam int CLK_MHZ = 10;

  // flag positions in a stream word, above the pixel bits
  localparam int FLAG_SOL = 0;
  localparam int FLAG_SOF = 1;
  localparam int FLAG_W   = 2;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_VONE  = 3'b001,
    ST_VTWO  = 3'b010,
    ST_HWAIT = 3'b011,
    ST_HCLK  = 3'b100,
    ST_DRAIN = 3'b101
  } ccdrs_state_t;

endpackage : ccdrs_pkg

// File: tb/ccdrs_chk.sv
// concurrent checks on the ccd readout sequencer ports
module ccdrs_chk
  import ccdrs_pkg::*;
#(
  parameter int PIX_W     = 12,
  parameter int RESUME_NS = 1000,
  parameter int VPULSE_NS = 1000
) (
  // clock, reset and control
  input wire logic                         ref_clk,
  input wire logic                         rst,
  input wire logic                         frameStart,
  input wire logic                         dualMode,
  // sensor phases
  input wire logic                         vertPhaseOne,
  input wire logic                         vertPhaseTwo,
  input wire logic                         horzPhaseOne,
  input wire logic                         horzPhaseTwo,
  input wire logic                         rightBarrierOne,
  input wire logic                         rightBarrierTwo,
  input wire logic                         lineDumpGate,
  // stream and status
  input wire logic [PIX_W+ccdrs_pkg::FLAG_W-1:0] pixData,
  input wire logic                         pixValid,
  input wire logic                         pixReady,
  input wire logic                         busy,
  input wire logic [ccdrs_pkg::CNT_W-1:0]  curRow
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulse and delay lengths round up to whole clock cycles
  localparam int VPM1 = (VPULSE_NS * CLK_MHZ + 999) / 1000 - 1;
  localparam int THM1 = (RESUME_NS * CLK_MHZ + 999) / 1000 - 1;
  logic        dual_r, dual_nxt;
  logic [10:0] pixCnt_r, pixCnt_nxt, lineWords_r, lineWords_nxt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // mode is latched at frame accept, since line length depends on it
  always_comb begin
    dual_nxt = (frameStart && !busy) ? dualMode : dual_r;
    pixCnt_nxt = vertPhaseOne ? 11'h000 : pixCnt_r + 11'(horzPhaseTwo);
    lineWords_nxt = lineWords_r;
    if (pixValid && pixReady) begin
      lineWords_nxt = pixData[PIX_W] ? 11'h001 : lineWords_r + 11'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dual_r      <= 1'b0;
      pixCnt_r    <= 11'h000;
      lineWords_r <= 11'h000;
    end else begin
      dual_r      <= dual_nxt;
      pixCnt_r    <= pixCnt_nxt;
      lineWords_r <= lineWords_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_frame_start: assert property (
    frameStart && !busy |=> busy && vertPhaseOne)
    else $error("frame accept did not start a vertical pulse");
  // the second phase rises as the first falls, so keep it out of that cycle
  a_vone_pulse: assert property (
    $rose(vertPhaseOne) |->
      (!vertPhaseTwo throughout (1'b1 ##VPM1 vertPhaseOne))
      ##1 !vertPhaseOne)
    else $error("first vertical pulse width wrong");
  a_vtwo_follows: assert property (
    $fell(vertPhaseOne) |->
      vertPhaseTwo ##VPM1 vertPhaseTwo ##1 !vertPhaseTwo)
    else $error("second vertical pulse missing or wrong width");
  a_halt_levels: assert property (
    vertPhaseOne || vertPhaseTwo |-> horzPhaseOne && !horzPhaseTwo)
    else $error("horizontal not halted during vertical shift");
  a_resume_delay: assert property (
    $fell(vertPhaseTwo) |->
      (horzPhaseOne && !horzPhaseTwo) throughout (1'b1 ##THM1 1'b1))
    else $error("horizontal clocking resumed too early");
  a_quiet_readout: assert property (
    horzPhaseTwo |-> !vertPhaseOne && !vertPhaseTwo && !lineDumpGate)
    else $error("vertical or dump pulsed during readout");
  a_dump_gate: assert property (
    lineDumpGate |-> vertPhaseOne || vertPhaseTwo)
    else $error("dump gate high outside a transfer");
  a_len_single: assert property (
    $rose(vertPhaseOne) && !dual_r |->
      pixCnt_r == 11'h000 || pixCnt_r == LINE_LEN_SGL)
    else $error("single line pixel count wrong");
  a_len_dual: assert property (
    $rose(vertPhaseOne) && dual_r |->
      pixCnt_r == 11'h000 || pixCnt_r == LINE_LEN_DUAL)
    else $error("dual half pixel count wrong");
  a_right_dir: assert property (
    busy && !vertPhaseOne |->
      (dual_r ? (rightBarrierOne == horzPhaseOne &&
                 rightBarrierTwo == horzPhaseTwo)
              : (rightBarrierOne == horzPhaseTwo &&
                 rightBarrierTwo == horzPhaseOne)))
    else $error("right half barrier phases wrong for mode");
  a_line_words: assert property (
    pixValid && pixReady && pixData[PIX_W] && lineWords_r != 11'h000 |->
      lineWords_r == COLS_IMAGE_SGL)
    else $error("image line word count wrong");
  a_image_rows: assert property (
    pixValid |-> curRow >= ROW_IMG_FIRST)
    else $error("stream word before first image row");
  a_word_hold: assert property (
    pixValid && !pixReady |=> pixValid && $stable(pixData))
    else $error("stream word dropped before accept");
endmodule : ccdrs_chk

// File: tb/ccdrs_sensor_model.sv
// behavioural sensor: vertical and horizontal charge shifting
module ccdrs_sensor_model #(
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             rst,
  // phase drive from the controller
  input wire logic             vertPhaseTwo,
  input wire logic             horzPhaseOne,
  input wire logic             horzPhaseTwo,
  input wire logic             rightBarrierOne,
  input wire logic             lineDumpGate,
  // video towards the converters
  output logic     [PIX_W-1:0] videoLeft,
  output logic     [PIX_W-1:0] videoRight
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        vTwoDly, dumpSeen, loaded;
  int          rowIdx, lineRow, pixIdx;
  logic [11:0] leftVal, rightVal;

  // charge at register position pos of row r; end cells get none
  function automatic logic [11:0] charge(int r, int pos);
    if (pos < 4 || pos > 1643) return 12'h000;
    if (r < 2 || r > 1209 || pos < 20 || pos > 1627) return 12'h00A;
    return 12'((r * 13 + pos * 5) % 4096);
  endfunction : charge

  // a row enters the horizontal register as the second phase falls
  always @(posedge ref_clk) begin
    if (rst) begin
      vTwoDly  <= 1'b0;
      dumpSeen <= 1'b0;
      loaded   <= 1'b0;
      rowIdx   <= 0;
      lineRow  <= 0;
      pixIdx   <= 0;
    end else begin
      vTwoDly <= vertPhaseTwo;
      if (vTwoDly && !vertPhaseTwo) begin
        lineRow  <= rowIdx;
        rowIdx   <= rowIdx + 1;
        loaded   <= !(dumpSeen || lineDumpGate);
        dumpSeen <= 1'b0;
        pixIdx   <= 0;
      end else begin
        dumpSeen <= dumpSeen || lineDumpGate;
        if (horzPhaseTwo) pixIdx <= pixIdx + 1;
      end
    end
  end

  // right half shifts from the far end only when its barriers follow the horizontal phases unswapped
  assign leftVal  = loaded ? charge(lineRow, pixIdx) : 12'h000;
  assign rightVal = loaded ? charge(lineRow, 1647 - pixIdx) : 12'h000;
  // between samples show inverted data so a stale value never matches
  assign videoLeft  = PIX_W'(horzPhaseTwo ? leftVal : ~leftVal);
  assign videoRight = PIX_W'((horzPhaseTwo && rightBarrierOne == horzPhaseOne)
                             ? rightVal : ~rightVal);
endmodule : ccdrs_sensor_model

// File: tb/tb.sv
// self-checking bench for the ccd readout sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PIX_W     = 12;
  localparam int RESUME_NS = 200;
  localparam int VPULSE_NS = 300;
  logic                 ref_clk, rst, clkEn, frameStart, dualMode;
  logic                 dumpReq, pixReady, stall, pixValid, busy;
  logic                 vertPhaseOne, vertPhaseTwo, horzPhaseOne;
  logic                 horzPhaseTwo, rightBarrierOne, rightBarrierTwo;
  logic                 lineDumpGate;
  logic [PIX_W-1:0]     videoLeft, videoRight;
  logic [PIX_W+1:0]     pixData;
  logic [10:0]          curRow;
  logic [PIX_W+1:0]     expQ[$];
  int                   error_cnt, tests_run;

  ccdrs_ctrl #(.PIX_W(PIX_W), .FIFO_D(4), .RESUME_NS(RESUME_NS),
    .VPULSE_NS(VPULSE_NS)) ccdrs_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .frameStart(frameStart),
    .dualMode(dualMode), .dumpReq(dumpReq), .videoLeft(videoLeft),
    .videoRight(videoRight), .vertPhaseOne(vertPhaseOne),
    .vertPhaseTwo(vertPhaseTwo), .horzPhaseOne(horzPhaseOne),
    .horzPhaseTwo(horzPhaseTwo), .rightBarrierOne(rightBarrierOne),
    .rightBarrierTwo(rightBarrierTwo), .lineDumpGate(lineDumpGate),
    .pixData(pixData), .pixValid(pixValid), .pixReady(pixReady),
    .busy(busy), .curRow(curRow));
  ccdrs_sensor_model #(.PIX_W(PIX_W)) ccdrs_sensor_model_inst (
    .ref_clk(ref_clk), .rst(rst), .vertPhaseTwo(vertPhaseTwo),
    .horzPhaseOne(horzPhaseOne), .horzPhaseTwo(horzPhaseTwo),
    .rightBarrierOne(rightBarrierOne), .lineDumpGate(lineDumpGate),
    .videoLeft(videoLeft), .videoRight(videoRight));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check_word(string what, logic [PIX_W+1:0] ex,
                            logic [PIX_W+1:0] seen);
    tests_run++;
    if (seen !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, ex, seen);
    end
  endtask : check_word

  task automatic check_bit(string what, logic ex, logic seen);
    tests_run++;
    if (seen !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, ex, seen);
    end
  endtask : check_bit

  // a hang counts as a mismatch and ends the run at once
  task automatic timed_out(string what);
    error_cnt++;
    $display("ERROR %s expected done seen timeout", what);
    wrap_up();
  endtask : timed_out

  task automatic wait_q(int left);
    int n = 0;
    while (expQ.size() > left && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 40000) timed_out("stream");
  endtask : wait_q

  task automatic wait_dump(int minRow);
    int n = 0;
    while (!(lineDumpGate === 1'b1 && curRow >= minRow) && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 5000) timed_out("dump gate");
  endtask : wait_dump

  // image column j sits at register position 24 + j: 4 empty, 16 dark, 4 spare
  task automatic note_row(int r, bit first);
    logic [11:0] v;
    for (int j = 0; j < 1600; j++) begin
      v = 12'((r * 13 + (24 + j) * 5) % 4096);
      expQ.push_back({first && j == 0, j == 0, PIX_W'(v)});
    end
  endtask : note_row

  // early rows are dumped to save time; rows 6 and 7 must stay clean, or rows 6 and 8 when row 7 is dumped mid-frame
  task automatic run_frame(bit dual, bit dumpMid);
    @(posedge ref_clk);
    dualMode   <= dual;
    dumpReq    <= 1'b1;
    frameStart <= 1'b1;
    note_row(6, 1'b1);
    note_row(dumpMid ? 8 : 7, 1'b0);
    @(posedge ref_clk);
    frameStart <= 1'b0;
    wait_dump(3);
    dumpReq    <= 1'b0;
    frameStart <= 1'b1;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    wait_q(3000);
    stall <= 1'b1;
    repeat (100) @(posedge ref_clk);
    stall <= 1'b0;
    if (dumpMid) begin
      dumpReq <= 1'b1;
      wait_dump(0);
      dumpReq <= 1'b0;
    end
    wait_q(0);
    check_bit("busy", 1'b1, busy);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check_bit("halted phase one", 1'b1, horzPhaseOne);
    check_bit("vertical idle", 1'b0, vertPhaseOne);
    check_bit("busy in reset", 1'b0, busy);
    rst <= 1'b0;
    $display("test %s frame done", dual ? "dual" : "single");
  endtask : run_frame

  // oldest note is compared against each word the consumer accepts
  always @(posedge ref_clk) begin
    if (!rst && pixValid === 1'b1 && pixReady) begin
      if (expQ.size() == 0) check_word("spare word", '0, pixData);
      else check_word("pixel word", expQ.pop_front(), pixData);
    end
  end

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    frameStart = 1'b0;
    dualMode = 1'b0;
    dumpReq = 1'b0;
    pixReady = 1'b0;
    stall = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(74));
    fork
      forever begin
        @(posedge ref_clk);
        pixReady <= !stall && ($urandom % 8 < 5);
      end
    join_none
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    run_frame(1'b0, 1'b0);
    run_frame(1'b1, 1'b1);
    wrap_up();
  end
endmodule : tb

bind ccdrs_ctrl ccdrs_chk #(.PIX_W(PIX_W), .RESUME_NS(RESUME_NS),
  .VPULSE_NS(VPULSE_NS)) ccdrs_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .frameStart(frameStart),
  .dualMode(dualMode), .vertPhaseOne(vertPhaseOne),
  .vertPhaseTwo(vertPhaseTwo), .horzPhaseOne(horzPhaseOne),
  .horzPhaseTwo(horzPhaseTwo), .rightBarrierOne(rightBarrierOne),
  .rightBarrierTwo(rightBarrierTwo), .lineDumpGate(lineDumpGate),
  .pixData(pixData), .pixValid(pixValid), .pixReady(pixReady),
  .busy(busy), .curRow(curRow));

// File: verilog/ccdrs_ctrl.sv
// ccd readout sequencer with output fifo and dual-output line rebuild
//
// Notes on behaviour
// - skip 4 buffer rows each end, 1200 kept
// - drop 4 buffer pixels each end, keep 1600
// - dual mode reverses right half shift direction
// - right data buffered, reversed, appended after left
// - vertical shift holds phase one high, two low
// - horizontal resumes after resume delay from fall
// - no vertical or dump pulses during readout
// - single mode clocks 1644 pixels per line
// - dual mode clocks 824 pixels per half

////////////////////////////////////////////////////////////////////////////
// shift-register fifo: head always in slot 0 so outputs come from flops
module ccdrs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic [DEPTH-1:0] shVld;
  logic             pop;
  logic             push;

  // full is honest: last slot occupied means no room
  assign pop  = vld_r[0] & outReady;
  assign push = inValid & ~vld_r[DEPTH-1];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : gSlot
      // shift down on pop, then fill the first empty slot
      always_comb begin
        logic [WIDTH-1:0] shData;
        logic             below;
        shData = mem_r[i];
        below  = 1'b0;
        shVld[i] = vld_r[i];
        if (pop) begin
          shData   = (i == DEPTH - 1) ? '0 : mem_r[(i + 1) % DEPTH];
          shVld[i] = (i == DEPTH - 1) ? 1'b0 : vld_r[(i + 1) % DEPTH];
        end
        below = (i == 0) ? 1'b1 : shVld[(i + DEPTH - 1) % DEPTH];
        mem_nxt[i] = shData;
        vld_nxt[i] = shVld[i];
        if (push && below && !shVld[i]) begin
          mem_nxt[i] = inData;
          vld_nxt[i] = 1'b1;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          mem_r[i] <= '0;
          vld_r[i] <= 1'b0;
        end else if (clkEn) begin
          mem_r[i] <= mem_nxt[i];
          vld_r[i] <= vld_nxt[i];
        end
      end
    end
  endgenerate

  assign inReady  = ~vld_r[DEPTH-1];
  assign outData  = mem_r[0];
  assign outValid = vld_r[0];
endmodule : ccdrs_fifo

////////////////////////////////////////////////////////////////////////////
// sequencer: drives the sensor phases and collects image pixels
module ccdrs_ctrl #(
  parameter int PIX_W     = 12,
  parameter int FIFO_D    = 4,
  parameter int RESUME_NS = 1000,  // horizontal resume delay
  parameter int VPULSE_NS = 1000   // width of each vertical phase pulse
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  // control
  input  wire logic                       frameStart,
  input  wire logic                       dualMode,
  input  wire logic                       dumpReq,
  // digitised video, same clock
  input  wire logic [PIX_W-1:0]           videoLeft,
  input  wire logic [PIX_W-1:0]           videoRight,
  // sensor phase drive
  output logic                            vertPhaseOne,
  output logic                            vertPhaseTwo,
  output logic                            horzPhaseOne,
  output logic                            horzPhaseTwo,
  output logic                            rightBarrierOne,
  output logic                            rightBarrierTwo,
  output logic                            lineDumpGate,
  // image stream
  output logic [PIX_W+ccdrs_pkg::FLAG_W-1:0] pixData,
  output logic                            pixValid,
  input  wire logic                       pixReady,
  // status
  output logic                            busy,
  output logic [ccdrs_pkg::CNT_W-1:0]     curRow
);
  import ccdrs_pkg::*;

  localparam int WORD_W = PIX_W + FLAG_W;
  localparam int BUF_AW = $clog2(int'(COLS_IMAGE_DUAL));
  localparam logic [15:0] RESUME_CYC =
    16'(((RESUME_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
        (RESUME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] VPULSE_CYC =
    16'(((VPULSE_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
        (VPULSE_NS * CLK_MHZ + 999) / 1000);

  // range decode, used for rows and for columns
  function automatic logic inRange(input logic [10:0] v,
                                   input logic [10:0] lo,
                                   input logic [10:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction : inRange

  ccdrs_state_t     state_r, state_nxt;
  logic [10:0]      row_r, row_nxt;
  logic [10:0]      col_r, col_nxt;
  logic [15:0]      tmr_r, tmr_nxt;
  logic             phase_r, phase_nxt;
  logic             dual_r, dual_nxt;
  logic             dump_r, dump_nxt;
  logic [PIX_W-1:0] lineBuf_r [int'(COLS_IMAGE_DUAL)];
  logic             bufWe;
  logic [BUF_AW-1:0] bufWa;
  logic [WORD_W-1:0] pushData;
  logic             pushValid;
  logic             fifoReady;
  logic             imgRow;
  logic             imgCol;
  logic [10:0]      lineLen;
  logic [10:0]      colLast;
  logic [10:0]      colOff;

  assign lineLen = dual_r ? LINE_LEN_DUAL : LINE_LEN_SGL;
  assign colLast = COL_IMG_FIRST - 11'h001 +
                   (dual_r ? COLS_IMAGE_DUAL : COLS_IMAGE_SGL);
  assign imgRow  = inRange(row_r, ROW_IMG_FIRST, ROW_IMG_LAST);
  assign imgCol  = inRange(col_r, COL_IMG_FIRST, colLast);
  assign colOff  = col_r - COL_IMG_FIRST;

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state; stalls only in phase 0 so phase one stays high
  always_comb begin
    state_nxt = state_r;
    row_nxt   = row_r;
    col_nxt   = col_r;
    tmr_nxt   = tmr_r;
    phase_nxt = phase_r;
    dual_nxt  = dual_r;
    dump_nxt  = dump_r;
    pushValid = 1'b0;
    pushData  = '0;
    bufWe     = 1'b0;
    bufWa     = colOff[BUF_AW-1:0];
    unique case (state_r)
      ST_IDLE: begin
        if (frameStart) begin
          dual_nxt  = dualMode;
          dump_nxt  = dumpReq;
          row_nxt   = '0;
          tmr_nxt   = VPULSE_CYC - 16'h0001;
          state_nxt = ST_VONE;
        end
      end
      ST_VONE: begin
        // two vertical pulses move every row one step
        if (tmr_r == '0) begin
          tmr_nxt   = VPULSE_CYC - 16'h0001;
          state_nxt = ST_VTWO;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      ST_VTWO: begin
        if (tmr_r == '0) begin
          tmr_nxt   = RESUME_CYC - 16'h0001;
          state_nxt = ST_HWAIT;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      ST_HWAIT: begin
        // count the resume delay from the falling vertical edge
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 16'h0001;
        end else if (dump_r) begin
          // dumped line never reached the register: skip readout
          col_nxt = lineLen;
        end else begin
          col_nxt   = '0;
          phase_nxt = 1'b0;
          state_nxt = ST_HCLK;
        end
      end
      ST_HCLK: begin
        if (!phase_r) begin
          // wait for room before the sample that needs it
          if (!(imgRow && imgCol) || fifoReady) begin
            phase_nxt = 1'b1;
          end
        end else begin
          // both outputs sampled on the same pixel edge in dual mode; single mode samples the left only
          if (imgRow && imgCol) begin
            pushValid = 1'b1;
            pushData  = {(row_r == ROW_IMG_FIRST) &&
                           (col_r == COL_IMG_FIRST),
                         col_r == COL_IMG_FIRST, videoLeft};
            bufWe     = dual_r;
          end
          phase_nxt = 1'b0;
          col_nxt   = col_r + 11'h001;
          if (col_r == lineLen - 11'h001) begin
            if (dual_r && imgRow) begin
              col_nxt   = COLS_IMAGE_DUAL - 11'h001;
              state_nxt = ST_DRAIN;
            end else begin
              col_nxt = lineLen;
            end
          end
        end
      end
      ST_DRAIN: begin
        // right half replayed last sample first, after left half
        if (fifoReady) begin
          pushValid = 1'b1;
          pushData  = {2'b00, lineBuf_r[col_r[BUF_AW-1:0]]};
          if (col_r == '0) begin
            col_nxt = lineLen;
          end else begin
            col_nxt = col_r - 11'h001;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // row finished: shift the next one or end the frame
    if (col_nxt == lineLen && state_r != ST_IDLE &&
        (state_r != ST_DRAIN || col_r == '0 && fifoReady)) begin
      col_nxt = '0;
      if (row_r == ROWS_TOTAL - 11'h001) begin
        state_nxt = ST_IDLE;
      end else begin
        row_nxt   = row_r + 11'h001;
        dump_nxt  = dumpReq;
        tmr_nxt   = VPULSE_CYC - 16'h0001;
        state_nxt = ST_VONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      row_r   <= '0;
      col_r   <= '0;
      tmr_r   <= '0;
      phase_r <= 1'b0;
      dual_r  <= 1'b0;
      dump_r  <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      row_r   <= row_nxt;
      col_r   <= col_nxt;
      tmr_r   <= tmr_nxt;
      phase_r <= phase_nxt;
      dual_r  <= dual_nxt;
      dump_r  <= dump_nxt;
    end
  end

  // right-half line store, flip-flops addressed by pixel offset
  always_ff @(posedge ref_clk) begin
    if (clkEn && bufWe) begin
      lineBuf_r[bufWa] <= videoRight;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase outputs: registered from the next state
  logic hOne_nxt, hTwo_nxt, vOne_nxt, vTwo_nxt, dumpGate_nxt;

  always_comb begin
    hOne_nxt = 1'b1;
    hTwo_nxt = 1'b0;
    if (state_nxt == ST_HCLK) begin
      hOne_nxt = ~phase_nxt;
      hTwo_nxt = phase_nxt;
    end
    vOne_nxt = (state_nxt == ST_VONE);
    vTwo_nxt = (state_nxt == ST_VTWO);
    // dump gate only rises with the transfer, never during readout
    dumpGate_nxt = dump_nxt && (vOne_nxt || vTwo_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vertPhaseOne    <= 1'b0;
      vertPhaseTwo    <= 1'b0;
      horzPhaseOne    <= 1'b1;
      horzPhaseTwo    <= 1'b0;
      rightBarrierOne <= 1'b0;
      rightBarrierTwo <= 1'b1;
      lineDumpGate    <= 1'b0;
      busy            <= 1'b0;
      curRow          <= '0;
    end else if (clkEn) begin
      vertPhaseOne    <= vOne_nxt;
      vertPhaseTwo    <= vTwo_nxt;
      horzPhaseOne    <= hOne_nxt;
      horzPhaseTwo    <= hTwo_nxt;
      // unswapped drive reverses the right half in dual mode; single mode swaps the phases
      rightBarrierOne <= dual_nxt ? hOne_nxt : hTwo_nxt;
      rightBarrierTwo <= dual_nxt ? hTwo_nxt : hOne_nxt;
      lineDumpGate    <= dumpGate_nxt;
      busy            <= (state_nxt != ST_IDLE);
      curRow          <= row_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output fifo; a full fifo holds the sequencer in phase 0
  ccdrs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_D)
  ) uFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inData   (pushData),
    .inValid  (pushValid),
    .inReady  (fifoReady),
    .outData  (pixData),
    .outValid (pixValid),
    .outReady (pixReady)
  );
endmodule : ccdrs_ctrl
